// ### ddpr_regs.sv
// Purpose: dual data pointer bank with auxiliary select and flag register
// Assumes: core strobes are one cycle, read data valid one cycle later
// Notes:   serial number reaches the outside only through the programming port
`timescale 1ns/1ns
module ddpr_regs #(
  parameter logic [ddpr_pkg::SERIAL_WIDTH-1:0] SERIAL_VALUE =
    ddpr_pkg::SERIAL_DEFAULT
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // Special register port
  input  wire logic [7:0]  sfr_addr,
  input  wire logic [7:0]  sfr_wdata,
  input  wire logic        sfr_wr,
  input  wire logic        sfr_rd,
  input  wire logic        sfr_inc,
  output logic [7:0]       sfr_rdata,
  // Core pointer operations
  input  wire logic        ptr_load,
  input  wire logic [15:0] ptr_load_val,
  input  wire logic        ptr_inc,
  output logic [15:0]      ptr_addr,
  // Reset source events
  input  wire logic        soft_reset_event,
  input  wire logic        reset_pin_event,
  input  wire logic        hard_fault_event,
  // Auxiliary outputs
  output logic             serial_pin_swap,
  // Programming port for the serial number
  input  wire logic        prog_serial_rd,
  input  wire logic [3:0]  prog_serial_idx,
  output logic [7:0]       prog_serial_data
);

  ddpr_pkg::ddpr_state_s   st_q;
  ddpr_pkg::ddpr_state_s   st_d;
  ddpr_pkg::ddpr_ptr_ctl_s ctl_act;
  ddpr_pkg::ddpr_ptr_ctl_s ctl_zero;
  ddpr_pkg::ddpr_ptr_ctl_s ctl_one;
  logic [15:0]             ptr_zero_q;
  logic [15:0]             ptr_one_q;
  logic [15:0]             ptr_zero_nxt;
  logic [15:0]             ptr_one_nxt;
  logic                    hit_low;
  logic                    hit_high;
  logic                    hit_aux;
  logic [7:0]              aux_rd;
  logic [15:0]             act_q;
  logic [ddpr_pkg::SERIAL_WIDTH-1:0] serial_shift;

  assign hit_low  = sfr_addr == ddpr_pkg::ADDR_PTR_LOW;
  assign hit_high = sfr_addr == ddpr_pkg::ADDR_PTR_HIGH;
  assign hit_aux  = sfr_addr == ddpr_pkg::ADDR_AUX;

  // Current active pointer, for reads of the byte registers
  assign act_q = st_q.aux.sel ? ptr_one_q : ptr_zero_q;

  // Auxiliary read image; reserved bit 4 reads 0
  always_comb begin
    aux_rd                          = ddpr_pkg::BYTE_ZERO;
    aux_rd[ddpr_pkg::AUX_BIT_SEL]   = st_q.aux.sel;
    aux_rd[ddpr_pkg::AUX_BIT_ZERO]  = 1'b0;
    aux_rd[ddpr_pkg::AUX_BIT_SWAP]  = st_q.aux.swap;
    aux_rd[ddpr_pkg::AUX_BIT_UFLAG] = st_q.aux.uflag;
    aux_rd[ddpr_pkg::AUX_BIT_FAULT] = st_q.aux.faultf;
    aux_rd[ddpr_pkg::AUX_BIT_PINF]  = st_q.aux.pinf;
    aux_rd[ddpr_pkg::AUX_BIT_SOFT]  = st_q.aux.softf;
  end

  // Byte and word operations go to the active pointer only
  always_comb begin
    ctl_act          = '0;
    ctl_act.wr_lo    = sfr_wr && hit_low;
    ctl_act.wr_hi    = sfr_wr && hit_high;
    ctl_act.inc_lo   = sfr_inc && hit_low;
    ctl_act.inc_hi   = sfr_inc && hit_high;
    ctl_act.load     = ptr_load;
    ctl_act.inc16    = ptr_inc;
    ctl_act.byte_val = sfr_wdata;
    ctl_act.word_val = ptr_load_val;
    ctl_zero         = '0;
    ctl_one          = '0;
    if (st_q.aux.sel) begin
      ctl_one = ctl_act;
    end else begin
      ctl_zero = ctl_act;
    end
  end

  ddpr_ptr_reg u_ptr_zero (
    .clk       (clk),
    .rst       (rst),
    .ctl       (ctl_zero),
    .value     (ptr_zero_q),
    .value_nxt (ptr_zero_nxt)
  );

  ddpr_ptr_reg u_ptr_one (
    .clk       (clk),
    .rst       (rst),
    .ctl       (ctl_one),
    .value     (ptr_one_q),
    .value_nxt (ptr_one_nxt)
  );

  assign serial_shift = SERIAL_VALUE >> {prog_serial_idx, 3'h0};

  always_comb begin
    st_d = st_q;
    // Auxiliary register write; bit 1 and bit 4 have no storage
    if (sfr_wr && hit_aux) begin
      st_d.aux.sel   = sfr_wdata[ddpr_pkg::AUX_BIT_SEL];
      st_d.aux.swap  = sfr_wdata[ddpr_pkg::AUX_BIT_SWAP];
      st_d.aux.uflag = sfr_wdata[ddpr_pkg::AUX_BIT_UFLAG];
      st_d.aux.faultf = sfr_wdata[ddpr_pkg::AUX_BIT_FAULT];
      st_d.aux.pinf   = sfr_wdata[ddpr_pkg::AUX_BIT_PINF];
      st_d.aux.softf  = sfr_wdata[ddpr_pkg::AUX_BIT_SOFT];
    end else if (sfr_inc && hit_aux) begin
      // Carry dies in the hard-wired zero, so only the select flips
      st_d.aux.sel = !st_q.aux.sel;
    end
    // Hardware set beats a software clear in the same cycle
    if (soft_reset_event) begin
      st_d.aux.softf = 1'b1;
    end
    if (reset_pin_event) begin
      st_d.aux.pinf = 1'b1;
    end
    if (hard_fault_event) begin
      st_d.aux.faultf = 1'b1;
    end
    // Address tracks the pointer that is active after this edge
    st_d.addr = st_d.aux.sel ? ptr_one_nxt : ptr_zero_nxt;
    // Read data stand for one cycle only; unmapped reads give zero
    st_d.rdata = ddpr_pkg::BYTE_ZERO;
    if (sfr_rd) begin
      if (hit_low) begin
        st_d.rdata = act_q[7:0];
      end else if (hit_high) begin
        st_d.rdata = act_q[15:8];
      end else if (hit_aux) begin
        st_d.rdata = aux_rd;
      end
    end
    // Serial number only through the programming port
    st_d.serial_data = ddpr_pkg::BYTE_ZERO;
    if (prog_serial_rd && prog_serial_idx < ddpr_pkg::SERIAL_BYTES) begin
      st_d.serial_data = serial_shift[7:0];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st_q <= ddpr_pkg::STATE_RESET;
    end else begin
      st_q <= st_d;
    end
  end

  assign sfr_rdata        = st_q.rdata;
  assign ptr_addr         = st_q.addr;
  assign serial_pin_swap  = st_q.aux.swap;
  assign prog_serial_data = st_q.serial_data;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  // Address output always equals the selected pointer
  property p_addr_follows_sel;
    ptr_addr == (st_q.aux.sel ? ptr_one_q : ptr_zero_q);
  endproperty
  a_addr_follows_sel: assert property (p_addr_follows_sel)
    else $error("address output differs from selected pointer");

  // Pointer bank and select come out of reset cleared
  property p_reset_values;
    $fell(rst) |-> (ptr_zero_q == ddpr_pkg::PTR_RESET)
      && (ptr_one_q == ddpr_pkg::PTR_RESET) && !st_q.aux.sel;
  endproperty
  a_reset_values: assert property (p_reset_values)
    else $error("pointers or select not cleared by reset");

  sequence s_sel_flip_wr;
    sfr_wr && hit_aux && !ptr_load && !ptr_inc
      && (sfr_wdata[ddpr_pkg::AUX_BIT_SEL] != st_q.aux.sel);
  endsequence

  // Newly inactive pointer keeps its value across a switch
  property p_inactive_kept;
    s_sel_flip_wr |=> (st_q.aux.sel ? ptr_zero_q == $past(ptr_zero_q)
                                    : ptr_one_q == $past(ptr_one_q));
  endproperty
  a_inactive_kept: assert property (p_inactive_kept)
    else $error("inactive pointer changed on select switch");

  property p_zero_bit_reads_zero;
    sfr_rd && hit_aux |=> !sfr_rdata[ddpr_pkg::AUX_BIT_ZERO];
  endproperty
  a_zero_bit_reads_zero: assert property (p_zero_bit_reads_zero)
    else $error("hard-wired zero bit read as one");

  sequence s_aux_inc;
    sfr_inc && hit_aux && !soft_reset_event
      && !reset_pin_event && !hard_fault_event;
  endsequence

  property p_aux_inc_toggles;
    s_aux_inc |=> (st_q.aux.sel != $past(st_q.aux.sel))
      && (st_q.aux.uflag == $past(st_q.aux.uflag))
      && (st_q.aux.swap == $past(st_q.aux.swap))
      && (st_q.aux.softf == $past(st_q.aux.softf));
  endproperty
  a_aux_inc_toggles: assert property (p_aux_inc_toggles)
    else $error("auxiliary increment disturbed other bits");

  property p_uflag_write;
    sfr_wr && hit_aux |=> ##1 sfr_rd && hit_aux |=>
      sfr_rdata[ddpr_pkg::AUX_BIT_UFLAG] == $past(st_q.aux.uflag);
  endproperty
  a_uflag_write: assert property (p_uflag_write)
    else $error("user flag read back wrong");

  property p_uflag_store;
    sfr_wr && hit_aux |=>
      st_q.aux.uflag == $past(sfr_wdata[ddpr_pkg::AUX_BIT_UFLAG]);
  endproperty
  a_uflag_store: assert property (p_uflag_store)
    else $error("user flag not written");

  property p_low_read;
    sfr_rd && hit_low |=> sfr_rdata == $past(ptr_addr[7:0]);
  endproperty
  a_low_read: assert property (p_low_read)
    else $error("low byte read not from active pointer");

  property p_high_read;
    sfr_rd && hit_high |=> sfr_rdata == $past(ptr_addr[15:8]);
  endproperty
  a_high_read: assert property (p_high_read)
    else $error("high byte read not from active pointer");

  property p_write_other_kept;
    sfr_wr && (hit_low || hit_high) && !st_q.aux.sel |=>
      ptr_one_q == $past(ptr_one_q);
  endproperty
  a_write_other_kept: assert property (p_write_other_kept)
    else $error("byte write reached the inactive pointer");

  property p_serial_hidden;
    sfr_rd && !hit_low && !hit_high && !hit_aux |=>
      sfr_rdata == ddpr_pkg::BYTE_ZERO;
  endproperty
  a_serial_hidden: assert property (p_serial_hidden)
    else $error("unmapped register read returned data");

  property p_serial_first_byte;
    prog_serial_rd && prog_serial_idx == 4'h0 |=>
      prog_serial_data == SERIAL_VALUE[7:0];
  endproperty
  a_serial_first_byte: assert property (p_serial_first_byte)
    else $error("serial number byte 0 wrong");

  property p_soft_reset_flag;
    soft_reset_event |=> st_q.aux.softf [*1] ##1 1'b1;
  endproperty
  a_soft_reset_flag: assert property (p_soft_reset_flag)
    else $error("soft reset flag not set by event");

endmodule // ddpr_regs

// ### ddpr_pkg.sv
// Purpose: constants and types for the dual data pointer register bank
// Assumes: 8-bit special register port, single clock, synchronous reset
// Notes:   all addresses, bit positions and reset values live here
//
// Overview of operation
// - Two independent 16-bit data pointers are kept side by side.
// - Auxiliary bit 0 selects: 0 picks pointer zero, 1 pointer one.
// - Switching the select leaves the now inactive pointer untouched.
// - Auxiliary bit 1 always reads 0 and ignores writes.
// - Incrementing the auxiliary register toggles only the select bit.
// - Auxiliary bit 3 is a free software flag with no hardware effect.
// - Low register holds pointer bits 7:0, high register bits 15:8.
// - The selected pointer drives the memory address output.
// - Low byte register sits at 82h and resets to zero.
// - High byte register sits at 83h and resets to zero.
// - A 96-bit serial number is readable only on the programming port.
// - Bit 7 sets on a software reset event; software may clear it.
package ddpr_pkg;

  localparam logic [7:0] ADDR_PTR_LOW  = 8'h82;
  localparam logic [7:0] ADDR_PTR_HIGH = 8'h83;
  localparam logic [7:0] ADDR_AUX      = 8'ha2;

  // Auxiliary register bit positions
  localparam int AUX_BIT_SEL   = 0;
  localparam int AUX_BIT_ZERO  = 1;
  localparam int AUX_BIT_SWAP  = 2;
  localparam int AUX_BIT_UFLAG = 3;
  localparam int AUX_BIT_FAULT = 5;
  localparam int AUX_BIT_PINF  = 6;
  localparam int AUX_BIT_SOFT  = 7;

  localparam logic [15:0] PTR_RESET  = 16'h0000;
  localparam logic [7:0]  BYTE_ZERO  = 8'h00;
  localparam logic [7:0]  BYTE_ONE   = 8'h01;
  localparam logic [15:0] WORD_ONE   = 16'h0001;

  localparam int          SERIAL_WIDTH = 96;
  localparam logic [3:0]  SERIAL_BYTES = 4'hc;
  // Arbitrary value, stands in for the factory-programmed serial number
  localparam logic [SERIAL_WIDTH-1:0] SERIAL_DEFAULT =
    96'h0123_4567_89ab_cdef_0f1e_2d3c;

  // Control for one pointer register
  typedef struct packed {
    logic        wr_lo;
    logic        wr_hi;
    logic        inc_lo;
    logic        inc_hi;
    logic        load;
    logic        inc16;
    logic [7:0]  byte_val;
    logic [15:0] word_val;
  } ddpr_ptr_ctl_s;

  typedef struct packed {
    logic [15:0] value;
  } ddpr_ptr_state_s;

  typedef struct packed {
    logic softf;
    logic pinf;
    logic faultf;
    logic uflag;
    logic swap;
    logic sel;
  } ddpr_aux_s;

  typedef struct packed {
    ddpr_aux_s   aux;
    logic [7:0]  rdata;
    logic [15:0] addr;
    logic [7:0]  serial_data;
  } ddpr_state_s;

  localparam ddpr_state_s STATE_RESET = '{
    aux: '0, rdata: BYTE_ZERO, addr: PTR_RESET, serial_data: BYTE_ZERO};

endpackage

// ### ddpr_ptr_reg.sv
// Purpose: one 16-bit data pointer with byte and word access
// Assumes: caller routes controls only to the active pointer
// Notes:   word load or word increment takes priority over byte access
`timescale 1ns/1ns
module ddpr_ptr_reg (
  // Clock and reset
  input  wire logic                     clk,
  input  wire logic                     rst,
  // Control
  input  wire ddpr_pkg::ddpr_ptr_ctl_s  ctl,
  // Value now and next
  output logic [15:0]                   value,
  output logic [15:0]                   value_nxt
);

  ddpr_pkg::ddpr_ptr_state_s st_q;
  ddpr_pkg::ddpr_ptr_state_s st_d;

  always_comb begin
    st_d = st_q;
    if (ctl.wr_lo) begin
      st_d.value[7:0] = ctl.byte_val;
    end else if (ctl.inc_lo) begin
      // Byte increment wraps without carry into the high byte
      st_d.value[7:0] = st_q.value[7:0] + ddpr_pkg::BYTE_ONE;
    end
    if (ctl.wr_hi) begin
      st_d.value[15:8] = ctl.byte_val;
    end else if (ctl.inc_hi) begin
      st_d.value[15:8] = st_q.value[15:8] + ddpr_pkg::BYTE_ONE;
    end
    if (ctl.load) begin
      st_d.value = ctl.word_val;
    end else if (ctl.inc16) begin
      st_d.value = st_q.value + ddpr_pkg::WORD_ONE;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st_q.value <= ddpr_pkg::PTR_RESET;
    end else begin
      st_q <= st_d;
    end
  end

  assign value     = st_q.value;
  assign value_nxt = st_d.value;

endmodule // ddpr_ptr_reg

// ### ddpr_xdata_model.sv
// Purpose: external data memory reached through the active pointer
// Assumes: pointer address is settled before the write edge
// Notes:   only the low address byte decodes; read is combinational
`timescale 1ns/1ns
module ddpr_xdata_model (
  // Clock
  input  wire logic        clk,
  // Memory access
  input  wire logic [15:0] addr,
  input  wire logic        wr,
  input  wire logic [7:0]  wdata,
  output logic [7:0]       rdata
);
  logic [7:0] mem [256];

  // Known pattern so a move can be checked
  initial begin
    for (int i = 0; i < 256; i++) begin
      mem[i] = 8'(i) ^ 8'h5a;
    end
  end

  always @(posedge clk) begin
    if (wr) begin
      mem[addr[7:0]] <= wdata;
    end
  end

  assign rdata = mem[addr[7:0]];
endmodule // ddpr_xdata_model

// ### tb_dual_data_pointer_regs.sv
// Purpose: self-checking bench for the dual pointer register bank
// Assumes: one strobe vector drives every request, changed once per edge
// Notes:   results are queued by the driver and popped by the monitor
`timescale 1ns/1ns
module tb_dual_data_pointer_regs;
  localparam logic [10:0] WR = 11'h400, RD = 11'h200, INC = 11'h100;
  localparam logic [10:0] LD = 11'h080, PI = 11'h040, SER = 11'h020;
  localparam logic [10:0] LOOK = 11'h010, SW = 11'h008, PIN = 11'h004;
  localparam logic [10:0] HF = 11'h002, XW = 11'h001;
  logic        clk, rst, sfr_wr, sfr_rd, sfr_inc, ptr_load, ptr_inc;
  logic        prog_serial_rd, look, soft_reset_event, reset_pin_event;
  logic        hard_fault_event, xw, rd_q, ser_q, serial_pin_swap;
  logic [10:0] strb;
  logic [7:0]  sfr_addr, sfr_wdata, sfr_rdata, prog_serial_data, xrdata, d;
  logic [15:0] ptr_load_val, ptr_addr, r0, r1;
  logic [3:0]  prog_serial_idx;
  logic [15:0] qr[$], qu[$], qp[$];
  int          mismatches, checks_done, cyc;

  assign {sfr_wr, sfr_rd, sfr_inc, ptr_load, ptr_inc, prog_serial_rd, look,
          soft_reset_event, reset_pin_event, hard_fault_event, xw} = strb;

  ddpr_regs ddpr_regs_inst (.clk, .rst, .sfr_addr, .sfr_wdata, .sfr_wr,
    .sfr_rd, .sfr_inc, .sfr_rdata, .ptr_load, .ptr_load_val, .ptr_inc,
    .ptr_addr, .soft_reset_event, .reset_pin_event, .hard_fault_event,
    .serial_pin_swap, .prog_serial_rd, .prog_serial_idx, .prog_serial_data);

  ddpr_xdata_model ddpr_xdata_model_inst (.clk, .addr(ptr_addr), .wr(xw),
    .wdata(sfr_wdata), .rdata(xrdata));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic chk(input string n, input logic [15:0] e, g);
    checks_done++;
    if (g !== e) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic tally_and_finish;
    if (mismatches == 0 && checks_done > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // Outputs must also read zero outside their one valid cycle
  always @(posedge clk) begin
    rd_q  <= sfr_rd;
    ser_q <= prog_serial_rd;
    cyc++;
    if (cyc == 3000) begin
      mismatches++;
      tally_and_finish;
    end
  end

  always @(negedge clk) begin
    if (!rst) begin
      chk("sfr_rdata", rd_q ? qr.pop_front() : 16'h0, {8'h0, sfr_rdata});
      chk("prog_serial_data", ser_q ? qu.pop_front() : 16'h0,
          {8'h0, prog_serial_data});
      if (look) begin
        chk("ptr_addr", qp.pop_front(), ptr_addr);
      end
    end
  end

  task automatic op(input logic [10:0] s, input logic [7:0] a,
                    input logic [15:0] v);
    @(posedge clk);
    strb         <= s;
    sfr_addr     <= a;
    sfr_wdata    <= v[7:0];
    ptr_load_val <= v;
    prog_serial_idx <= a[3:0];
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    qr.push_back({8'h0, e});
    op(RD, a, 16'h0);
  endtask

  task automatic lk(input logic [15:0] e);
    qp.push_back(e);
    op(LOOK, 8'h0, 16'h0);
  endtask

  task automatic w16(input logic [15:0] v);
    op(WR, 8'h82, v);
    op(WR, 8'h83, v >> 8);
  endtask

  initial begin
    rst = 1'b1;
    strb = 11'h0;
    sfr_addr = 8'h0;
    sfr_wdata = 8'h0;
    ptr_load_val = 16'h0;
    prog_serial_idx = 4'h0;
    r0 = 16'($urandom(32'h5168c92a));
    r1 = 16'($urandom);
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    rd(8'h82, 8'h00);
    rd(8'h83, 8'h00);
    rd(8'ha2, 8'h00);
    w16(r0);
    lk(r0);
    rd(8'h82, r0[7:0]);
    rd(8'h83, r0[15:8]);
    op(INC, 8'ha2, 16'h0);
    lk(16'h0);
    w16(r1);
    lk(r1);
    rd(8'h83, r1[15:8]);
    op(INC, 8'ha2, 16'h0);
    lk(r0);
    op(WR, 8'ha2, 16'hff);
    rd(8'ha2, 8'hed);
    lk(r1);
    @(negedge clk);
    chk("serial_pin_swap", 16'h1, {15'h0, serial_pin_swap});
    op(INC, 8'ha2, 16'h0);
    rd(8'ha2, 8'hec);
    op(WR, 8'ha2, 16'h08);
    rd(8'ha2, 8'h08);
    op(WR, 8'ha2, 16'h0);
    op(SW, 8'h0, 16'h0);
    rd(8'ha2, 8'h80);
    op(WR, 8'ha2, 16'h0);
    op(PIN, 8'h0, 16'h0);
    op(HF, 8'h0, 16'h0);
    rd(8'ha2, 8'h60);
    // Flag set must win over a same-cycle software clear
    op(WR | SW, 8'ha2, 16'h0);
    rd(8'ha2, 8'h80);
    op(WR, 8'ha2, 16'h0);
    op(LD, 8'h0, 16'hffff);
    op(PI, 8'h0, 16'h0);
    lk(16'h0);
    op(WR, 8'h83, 16'h12);
    op(WR, 8'h82, 16'hff);
    op(INC, 8'h82, 16'h0);
    lk(16'h1200);
    op(INC, 8'h83, 16'h0);
    lk(16'h1300);
    op(WR, 8'h81, 16'haa);
    rd(8'h81, 8'h00);
    for (int i = 0; i < 13; i++) begin
      qu.push_back(i < 12 ? {8'h0, ddpr_pkg::SERIAL_DEFAULT[8*i +: 8]}
                          : 16'h0);
      op(SER, 8'(i), 16'h0);
    end
    // Block move: pointer zero is destination, pointer one is source
    op(LD, 8'h0, 16'h0040);
    op(INC, 8'ha2, 16'h0);
    op(LD, 8'h0, 16'h0010);
    for (int i = 0; i < 4; i++) begin
      op(11'h0, 8'h0, 16'h0);
      @(negedge clk) d = xrdata;
      op(INC, 8'ha2, 16'h0);
      op(XW, 8'h0, {8'h0, d});
      op(PI, 8'h0, 16'h0);
      op(INC, 8'ha2, 16'h0);
      op(PI, 8'h0, 16'h0);
    end
    lk(16'h0014);
    op(INC, 8'ha2, 16'h0);
    lk(16'h0044);
    for (int i = 0; i < 4; i++) begin
      chk("xdata", {8'h0, 8'(8'h10 + i) ^ 8'h5a},
          {8'h0, ddpr_xdata_model_inst.mem[8'h40 + i]});
    end
    // Reset again in mid-run with pointers and select disturbed
    op(WR, 8'ha2, 16'h05);
    op(11'h0, 8'h0, 16'h0);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rd(8'ha2, 8'h00);
    lk(16'h0);
    @(negedge clk);
    chk("serial_pin_swap", 16'h0, {15'h0, serial_pin_swap});
    op(11'h0, 8'h0, 16'h0);
    repeat (3) @(posedge clk);
    tally_and_finish;
  end
endmodule // tb_dual_data_pointer_regs
